// ===== include/rx_regs_pkg.sv
package rx_regs_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [4:0] ADDR_DUTY_CTRL = 5'h09;
    localparam logic [4:0] ADDR_TAG_CFG   = 5'h0a;
    localparam logic [4:0] ADDR_PRE_CFG   = 5'h0b;
    localparam logic [4:0] ADDR_SIGNAL_STRENGTH_RESULT      = 5'h0c;
    // Address counter folds back to zero after this one
    localparam logic [4:0] ADDR_LAST      = 5'h1f;

    localparam logic [7:0] RESET_DUTY_CTRL = 8'h7f;
    localparam logic [7:0] RESET_TAG_CFG   = 8'hc0;
    localparam logic [7:0] RESET_PRE_CFG   = 8'h80;
    localparam logic [7:0] RESET_SIGNAL_STRENGTH_RESULT      = 8'h00;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BANK_BIT   = 7;
    localparam int ON_LSB     = 3;
    localparam int OFF_LSB    = 0;
    localparam int LEN_LSB    = 6;
    localparam int NIBBLE_LSB = 4;
    localparam int CMD_WR_BIT = 7;
    localparam int CMD_N_LSB  = 5;

    // Pin vector positions in the synchroniser
    localparam int PIN_SCLK   = 0;
    localparam int PIN_MOSI   = 1;
    localparam int PIN_CS     = 2;
    localparam int PIN_XTAL   = 3;
    localparam int PIN_STROBE = 4;
    localparam int PIN_COUNT  = 5;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLOCK_NS        = 25;
    localparam int DIGCLK_NS       = 25;
    localparam int DIGCLK_CYCLES   = (DIGCLK_NS / CLOCK_NS < 1) ? 1
                                     : DIGCLK_NS / CLOCK_NS;
    localparam int ON_UNIT_PERIODS = 512;
    localparam logic [9:0] ON_UNIT_CYCLES =
        10'(ON_UNIT_PERIODS * DIGCLK_CYCLES);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAKE = 2'b01,
        ST_ON   = 2'b10,
        ST_OFF  = 2'b11
    } strobe_state_t;

    // Off time in strobe periods per code
    function automatic logic [5:0] off_multiple(input logic [2:0] code);
        logic [5:0] m;
        m = 6'h01;
        unique case (code)
            3'h0: m = 6'h01;
            3'h1: m = 6'h02;
            3'h2: m = 6'h04;
            3'h3: m = 6'h08;
            3'h4: m = 6'h0c;
            3'h5: m = 6'h10;
            3'h6: m = 6'h20;
            3'h7: m = 6'h3f;
        endcase
        return m;
    endfunction

endpackage

// ===== include/rx_timer_if.sv
`timescale 1ns/1ps
interface rx_timer_if;
    logic [3:0] on_count;
    logic [2:0] off_sel;
    logic       strobe_en;
    logic       xtal_ready;
    logic       strobe_tick;
    logic       rx_on;
    logic       xtal_enable;

    modport regs (
        output on_count,
        output off_sel,
        output strobe_en,
        output xtal_ready,
        output strobe_tick,
        input  rx_on,
        input  xtal_enable
    );
    modport timer (
        input  on_count,
        input  off_sel,
        input  strobe_en,
        input  xtal_ready,
        input  strobe_tick,
        output rx_on,
        output xtal_enable
    );
endinterface

// ===== core/rx_strobe_timer.sv
`timescale 1ns/1ps
module rx_strobe_timer (
    input  wire logic   clock,
    input  wire logic   resetn,
    input  wire logic   ce,
    rx_timer_if.timer   tif
);
    rx_regs_pkg::strobe_state_t state;
    rx_regs_pkg::strobe_state_t next_state;
    logic [9:0] unit_cnt;
    logic [3:0] on_left;
    logic [5:0] off_left;
    logic       unit_end;
    logic [3:0] on_units;

    // Forbidden zero code falls back to one unit
    assign on_units = (tif.on_count == 4'h0) ? 4'h1 : tif.on_count;
    assign unit_end = (unit_cnt == 10'h000);

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            rx_regs_pkg::ST_IDLE: begin
                if (tif.strobe_en)
                    next_state = rx_regs_pkg::ST_WAKE;
            end
            rx_regs_pkg::ST_WAKE: begin
                if (tif.xtal_ready)
                    next_state = rx_regs_pkg::ST_ON;
            end
            rx_regs_pkg::ST_ON: begin
                if (unit_end && on_left == 4'h0)
                    next_state = rx_regs_pkg::ST_OFF;
            end
            rx_regs_pkg::ST_OFF: begin
                if (tif.strobe_tick && off_left == 6'h00)
                    next_state = rx_regs_pkg::ST_WAKE;
            end
        endcase
        if (!tif.strobe_en)
            next_state = rx_regs_pkg::ST_IDLE;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            state <= rx_regs_pkg::ST_IDLE;
        else if (ce)
            state <= next_state;
    end

    // On time: units of 512 digital clocks, reloaded on every wake
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            unit_cnt <= 10'h000;
            on_left  <= 4'h0;
        end else if (ce) begin
            if (state == rx_regs_pkg::ST_WAKE) begin
                unit_cnt <= rx_regs_pkg::ON_UNIT_CYCLES - 10'h001;
                on_left  <= on_units - 4'h1;
            end else if (state == rx_regs_pkg::ST_ON) begin
                if (unit_end) begin
                    unit_cnt <= rx_regs_pkg::ON_UNIT_CYCLES - 10'h001;
                    on_left  <= on_left - 4'h1;
                end else begin
                    unit_cnt <= unit_cnt - 10'h001;
                end
            end
        end
    end

    // Off time counted in strobe oscillator periods
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            off_left <= 6'h00;
        end else if (ce) begin
            if (state == rx_regs_pkg::ST_ON)
                off_left <= rx_regs_pkg::off_multiple(tif.off_sel)
                            - 6'h01;
            else if (state == rx_regs_pkg::ST_OFF && tif.strobe_tick)
                off_left <= off_left - 6'h01;
        end
    end

    assign tif.rx_on       = (state == rx_regs_pkg::ST_ON);
    assign tif.xtal_enable = (state == rx_regs_pkg::ST_WAKE)
                             || (state == rx_regs_pkg::ST_ON);
endmodule

// ===== core/rx_strobe_id_header_regs.sv
`timescale 1ns/1ps
// What this block does
// - bit 7 of duty control selects bank
// - receiver on for N times 512 clocks
// - off time is coded multiple of strobe
// - tag length code gives 2,4,5,6 bits
// - tag Manchester coded, LSB at bit 0
// - preamble length code gives 1,2,4,6 bits
// - preamble Manchester coded, LSB at bit 0
// - upper strength nibble is LNA level
// - lower strength nibble is IF level
// - burst starts at base, address increments
// - active-bank flag high for bank A
module rx_strobe_id_header_regs (
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       ce,
    input  wire logic       sclk,
    input  wire logic       mosi,
    input  wire logic       cs_n,
    output logic            miso,
    output logic            miso_oe,
    input  wire logic       xtal_ready,
    input  wire logic       strobe_osc,
    input  wire logic       strobe_en,
    input  wire logic [3:0] lna_level,
    input  wire logic [3:0] if_level,
    input  wire logic       signal_strength_result_valid,
    output logic            bank_a_active,
    output logic [2:0]      tag_length,
    output logic [5:0]      tag_value,
    output logic [11:0]     tag_manchester,
    output logic [2:0]      preamble_length,
    output logic [5:0]      preamble_value,
    output logic [11:0]     preamble_manchester,
    output logic            rx_on,
    output logic            xtal_enable
);
    localparam int P = rx_regs_pkg::PIN_COUNT;

    logic [P-1:0] pin_s1;
    logic [P-1:0] pin_s2;
    logic [P-1:0] pin_s3;
    logic [P-1:0] pin_filt;
    logic [P-1:0] pin_prev;
    logic [P-1:0] next_filt;

    logic [7:0] rx_duty_cycle_ctrl;
    logic [7:0] match_tag_cfg;
    logic [7:0] preamble_word_cfg;
    logic [7:0] signal_strength_result;

    logic       frame;
    logic       sclk_rise;
    logic       sclk_fall;
    logic [2:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] byte_val;
    logic       byte_done;
    logic       have_cmd;
    logic       is_write;
    logic       done;
    logic [1:0] left;
    logic [4:0] addr;
    logic [4:0] next_addr;
    logic [7:0] tx_shift;
    logic       skip_fall;
    logic       wr_en;

    logic [2:0]  next_tag_len;
    logic [2:0]  next_pre_len;
    logic [5:0]  next_tag_val;
    logic [5:0]  next_pre_val;
    logic [11:0] next_tag_man;
    logic [11:0] next_pre_man;

    rx_timer_if tif ();

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Three stages; a change is taken once stages two and three agree
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pin_s1   <= 5'h04;
            pin_s2   <= 5'h04;
            pin_s3   <= 5'h04;
            pin_filt <= 5'h04;
            pin_prev <= 5'h04;
        end else if (ce) begin
            pin_s1   <= {strobe_osc, xtal_ready, cs_n, mosi, sclk};
            pin_s2   <= pin_s1;
            pin_s3   <= pin_s2;
            pin_filt <= next_filt;
            pin_prev <= pin_filt;
        end
    end

    assign next_filt = (~(pin_s2 ^ pin_s3) & pin_s3)
                       | ((pin_s2 ^ pin_s3) & pin_filt);

    assign frame     = ~pin_filt[rx_regs_pkg::PIN_CS];
    assign sclk_rise = frame & pin_filt[rx_regs_pkg::PIN_SCLK]
                       & ~pin_prev[rx_regs_pkg::PIN_SCLK];
    assign sclk_fall = frame & ~pin_filt[rx_regs_pkg::PIN_SCLK]
                       & pin_prev[rx_regs_pkg::PIN_SCLK];

    // ----------------------------------------
    // Serial register port
    // ----------------------------------------
    // Byte assembly, MSB first, sampled on the rising edge
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bit_cnt  <= 3'h0;
            rx_shift <= 8'h00;
        end else if (ce) begin
            if (!frame) begin
                bit_cnt <= 3'h0;
            end else if (sclk_rise) begin
                bit_cnt  <= bit_cnt + 3'h1;
                rx_shift <= byte_val;
            end
        end
    end

    assign byte_val  = {rx_shift[6:0], pin_filt[rx_regs_pkg::PIN_MOSI]};
    assign byte_done = sclk_rise && (bit_cnt == 3'h7);
    assign wr_en     = byte_done && have_cmd && is_write && !done;

    // Wrap to address zero after the last one
    assign next_addr = (addr == rx_regs_pkg::ADDR_LAST) ? 5'h00
                       : addr + 5'h01;

    // Command byte, then one register per byte up to the count plus one
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            have_cmd <= 1'b0;
            is_write <= 1'b0;
            done     <= 1'b0;
            left     <= 2'h0;
            addr     <= 5'h00;
        end else if (ce) begin
            if (!frame) begin
                have_cmd <= 1'b0;
                done     <= 1'b0;
            end else if (byte_done) begin
                if (!have_cmd) begin
                    have_cmd <= 1'b1;
                    is_write <= byte_val[rx_regs_pkg::CMD_WR_BIT];
                    left     <= byte_val[rx_regs_pkg::CMD_N_LSB +: 2];
                    addr     <= byte_val[4:0];
                end else if (!done) begin
                    addr <= next_addr;
                    if (left == 2'h0)
                        done <= 1'b1;
                    else
                        left <= left - 2'h1;
                end
            end
        end
    end

    // Read data: loaded at a byte end, shifted out on falling edges.
    // The fall right after a load is skipped so bit 7 is not lost.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tx_shift  <= 8'h00;
            skip_fall <= 1'b0;
        end else if (ce) begin
            if (!frame) begin
                tx_shift  <= 8'h00;
                skip_fall <= 1'b0;
            end else if (byte_done) begin
                skip_fall <= 1'b1;
                if (!have_cmd && !byte_val[rx_regs_pkg::CMD_WR_BIT])
                    tx_shift <= read_reg(byte_val[4:0]);
                else if (have_cmd && !is_write && !done && left != 2'h0)
                    tx_shift <= read_reg(next_addr);
                else
                    tx_shift <= 8'h00;
            end else if (sclk_fall) begin
                if (skip_fall)
                    skip_fall <= 1'b0;
                else
                    tx_shift <= {tx_shift[6:0], 1'b0};
            end
        end
    end

    assign miso    = tx_shift[7];
    assign miso_oe = frame;

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    function automatic logic [7:0] read_reg(input logic [4:0] a);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            rx_regs_pkg::ADDR_DUTY_CTRL: d = rx_duty_cycle_ctrl;
            rx_regs_pkg::ADDR_TAG_CFG:   d = match_tag_cfg;
            rx_regs_pkg::ADDR_PRE_CFG:   d = preamble_word_cfg;
            rx_regs_pkg::ADDR_SIGNAL_STRENGTH_RESULT:      d = signal_strength_result;
            default:                     d = 8'h00;
        endcase
        return d;
    endfunction

    // Writable registers; the strength result ignores writes
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rx_duty_cycle_ctrl <= rx_regs_pkg::RESET_DUTY_CTRL;
            match_tag_cfg      <= rx_regs_pkg::RESET_TAG_CFG;
            preamble_word_cfg  <= rx_regs_pkg::RESET_PRE_CFG;
        end else if (ce && wr_en) begin
            if (addr == rx_regs_pkg::ADDR_DUTY_CTRL)
                rx_duty_cycle_ctrl <= byte_val;
            if (addr == rx_regs_pkg::ADDR_TAG_CFG)
                match_tag_cfg <= byte_val;
            if (addr == rx_regs_pkg::ADDR_PRE_CFG)
                preamble_word_cfg <= byte_val;
        end
    end

    // Converter results land whenever a conversion completes
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            signal_strength_result <= rx_regs_pkg::RESET_SIGNAL_STRENGTH_RESULT;
        end else if (ce && signal_strength_result_valid) begin
            signal_strength_result[rx_regs_pkg::NIBBLE_LSB +: 4]
                <= lna_level;
            signal_strength_result[3:0] <= if_level;
        end
    end

    // ----------------------------------------
    // Word recognition settings
    // ----------------------------------------
    function automatic logic [5:0] len_mask(input logic [2:0] len);
        logic [6:0] t;
        t = (7'h01 << len) - 7'h01;
        return t[5:0];
    endfunction

    function automatic logic [11:0] manchester(input logic [5:0] v,
                                               input logic [5:0] m);
        logic [11:0] r;
        r = 12'h000;
        for (int i = 0; i < 6; i++) begin
            if (m[i])
                r[2*i +: 2] = v[i] ? 2'b10 : 2'b01;
        end
        return r;
    endfunction

    // Length decode and LSB-aligned masking of the stored values
    always_comb begin
        unique case (match_tag_cfg[rx_regs_pkg::LEN_LSB +: 2])
            2'h0: next_tag_len = 3'h2;
            2'h1: next_tag_len = 3'h4;
            2'h2: next_tag_len = 3'h5;
            2'h3: next_tag_len = 3'h6;
        endcase
        unique case (preamble_word_cfg[rx_regs_pkg::LEN_LSB +: 2])
            2'h0: next_pre_len = 3'h1;
            2'h1: next_pre_len = 3'h2;
            2'h2: next_pre_len = 3'h4;
            2'h3: next_pre_len = 3'h6;
        endcase
        next_tag_val = match_tag_cfg[5:0] & len_mask(next_tag_len);
        next_pre_val = preamble_word_cfg[5:0]
                       & len_mask(next_pre_len);
        next_tag_man = manchester(match_tag_cfg[5:0],
                                  len_mask(next_tag_len));
        next_pre_man = manchester(preamble_word_cfg[5:0],
                                  len_mask(next_pre_len));
    end

    // Registered copies for the data manager, one cycle behind
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tag_length          <= 3'h0;
            tag_value           <= 6'h00;
            tag_manchester      <= 12'h000;
            preamble_length     <= 3'h0;
            preamble_value      <= 6'h00;
            preamble_manchester <= 12'h000;
            bank_a_active       <= 1'b0;
        end else if (ce) begin
            tag_length          <= next_tag_len;
            tag_value           <= next_tag_val;
            tag_manchester      <= next_tag_man;
            preamble_length     <= next_pre_len;
            preamble_value      <= next_pre_val;
            preamble_manchester <= next_pre_man;
            bank_a_active       <=
                rx_duty_cycle_ctrl[rx_regs_pkg::BANK_BIT];
        end
    end

    // ----------------------------------------
    // Strobe timer hookup
    // ----------------------------------------
    assign tif.on_count    = rx_duty_cycle_ctrl[rx_regs_pkg::ON_LSB +: 4];
    assign tif.off_sel     = rx_duty_cycle_ctrl[rx_regs_pkg::OFF_LSB +: 3];
    assign tif.strobe_en   = strobe_en;
    assign tif.xtal_ready  = pin_filt[rx_regs_pkg::PIN_XTAL];
    assign tif.strobe_tick = pin_filt[rx_regs_pkg::PIN_STROBE]
                             & ~pin_prev[rx_regs_pkg::PIN_STROBE];
    assign rx_on           = tif.rx_on;
    assign xtal_enable     = tif.xtal_enable;

    rx_strobe_timer timer_u (
        .clock  (clock),
        .resetn (resetn),
        .ce     (ce),
        .tif    (tif)
    );
endmodule

// ===== verif/rx_regs_asserts.sv
`timescale 1ns/1ps
// --------------------
// Port checker
// --------------------
module rx_regs_asserts (
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        cs_n,
    input wire logic        miso_oe,
    input wire logic        strobe_en,
    input wire logic [2:0]  tag_length,
    input wire logic [5:0]  tag_value,
    input wire logic [11:0] tag_manchester,
    input wire logic [2:0]  preamble_length,
    input wire logic [5:0]  preamble_value,
    input wire logic [11:0] preamble_manchester,
    input wire logic        rx_on,
    input wire logic        xtal_enable
);
    logic [15:0] on_cycles;

    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    // Pair code per bit, zero beyond the length
    function automatic logic [11:0] manch(logic [5:0] v, logic [2:0] n);
        manch = 12'h000;
        for (int i = 0; i < 6; i++)
            if (i < n) manch[2*i +: 2] = v[i] ? 2'b10 : 2'b01;
    endfunction

    // Length of the running on phase, so long holds need no repetition
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            on_cycles <= 16'h0000;
        else
            on_cycles <= rx_on ? on_cycles + 16'h0001 : 16'h0000;
    end

    chk_tag_len: assert property (
        $past(resetn) |-> tag_length inside {3'h2, 3'h4, 3'h5, 3'h6})
        else $error("tag length outside its code set");
    chk_pre_len: assert property (
        $past(resetn) |-> preamble_length inside {3'h1, 3'h2, 3'h4, 3'h6})
        else $error("preamble length outside its code set");
    chk_tag_low_bits: assert property (
        (tag_value >> tag_length) == 6'h00)
        else $error("tag value has bits above its length");
    chk_pre_low_bits: assert property (
        (preamble_value >> preamble_length) == 6'h00)
        else $error("preamble value has bits above its length");
    chk_tag_coding: assert property (
        tag_manchester == manch(tag_value, tag_length))
        else $error("tag pair coding wrong");
    chk_pre_coding: assert property (
        preamble_manchester == manch(preamble_value, preamble_length))
        else $error("preamble pair coding wrong");
    chk_on_needs_xtal: assert property (rx_on |-> xtal_enable)
        else $error("receiver on without crystal enable");
    chk_on_units: assert property (
        $fell(rx_on) && $past(strobe_en) |->
            on_cycles[8:0] == 9'h000 && on_cycles != 16'h0000)
        else $error("on phase not a whole number of units");
    chk_idle_off: assert property (
        !strobe_en [*2] |-> !rx_on && !xtal_enable)
        else $error("sequencer not idle with strobe disabled");
    chk_oe_idle: assert property (cs_n [*8] |-> !miso_oe)
        else $error("data out driven outside a frame");
    chk_oe_frame: assert property (!cs_n [*8] |-> miso_oe)
        else $error("data out not driven inside a frame");
endmodule

bind rx_strobe_id_header_regs rx_regs_asserts i_rx_regs_asserts (
    .clock, .resetn, .cs_n, .miso_oe, .strobe_en, .tag_length, .tag_value,
    .tag_manchester, .preamble_length, .preamble_value,
    .preamble_manchester, .rx_on, .xtal_enable);

// ===== verif/host_spi_model.sv
`timescale 1ns/1ps
// --------------------
// Host side of serial port
// --------------------
module host_spi_model (
    input  wire logic clock,
    input  wire logic miso,
    output logic      sclk,
    output logic      mosi,
    output logic      cs_n
);
    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
        cs_n = 1'b1;
    end

    // Six clocks per phase, beyond the pin filter delay
    task automatic ticks(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Mode 0, MSB first; data out taken just before each rise
    task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi <= tx[i];
            ticks(6);
            rx[i] = miso;
            sclk <= 1'b1;
            ticks(6);
            sclk <= 1'b0;
        end
    endtask

    // Command byte then n data bytes in one frame
    task automatic frame(input logic [7:0] cmd, input int n,
                         input logic [7:0] wr [4],
                         output logic [7:0] rd [4]);
        logic [7:0] junk;
        ticks(1);
        cs_n <= 1'b0;
        xfer_byte(cmd, junk);
        for (int k = 0; k < n; k++)
            xfer_byte(wr[k], rd[k]);
        ticks(6);
        cs_n <= 1'b1;
        // Deselected line is not held at its last value
        mosi <= ~mosi;
        ticks(10);
    endtask
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ps
// --------------------
// Register and strobe bench
// --------------------
module tb;
    typedef struct {
        logic [7:0] tcfg;
        logic [7:0] pcfg;
        logic [2:0] tl;
        logic [5:0] tv;
        logic [2:0] pl;
        logic [5:0] pv;
    } row_t;

    logic        clock, sclk, mosi, cs_n, miso, miso_oe;
    logic        resetn = 1'b0, xtal_ready = 1'b0, strobe_osc = 1'b0;
    logic        strobe_en = 1'b0, signal_strength_result_valid = 1'b0;
    logic [3:0]  lna_level = 4'h0, if_level = 4'h0;
    logic        bank_a_active, rx_on, xtal_enable;
    logic [2:0]  tag_length, preamble_length;
    logic [5:0]  tag_value, preamble_value;
    logic [11:0] tag_manchester, preamble_manchester;
    logic [7:0]  wb [4];
    logic [7:0]  rb [4];
    logic [7:0]  rst_vals [4] = '{8'h7f, 8'hc0, 8'h80, 8'h00};
    int          bad_count = 0, n_compared = 0;
    int          offm [8] = '{1, 2, 4, 8, 12, 16, 32, 63};
    row_t        rows [4] = '{
        '{8'h3f, 8'h3f, 3'h2, 6'h03, 3'h1, 6'h01},
        '{8'h7f, 8'h55, 3'h4, 6'h0f, 3'h2, 6'h01},
        '{8'h95, 8'haa, 3'h5, 6'h15, 3'h4, 6'h0a},
        '{8'hea, 8'hd5, 3'h6, 6'h2a, 3'h6, 6'h15}
    };

    rx_strobe_id_header_regs i_rx_strobe_id_header_regs (
        .clock, .resetn, .ce(1'b1), .sclk, .mosi, .cs_n, .miso, .miso_oe,
        .xtal_ready, .strobe_osc, .strobe_en, .lna_level, .if_level,
        .signal_strength_result_valid, .bank_a_active, .tag_length, .tag_value,
        .tag_manchester, .preamble_length, .preamble_value,
        .preamble_manchester, .rx_on, .xtal_enable);
    host_spi_model i_host_spi_model (.clock, .miso, .sclk, .mosi, .cs_n);

    // 40 MHz system clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Case equality so an unknown never matches
    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got,
                     exp);
        end
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Frame length follows the count field of the command
    task automatic burst(input logic [7:0] cmd);
        i_host_spi_model.frame(cmd, int'(cmd[6:5]) + 1, wb, rb);
        @(negedge clock);
    endtask

    // Bounded wait for the receiver to switch on
    task automatic wait_on();
        int k;
        k = 0;
        while (rx_on !== 1'b1 && k < 200) begin
            @(negedge clock);
            k++;
        end
        if (k == 200)
            give_up("receiver on");
    endtask

    // Used-up wait bound counts as a mismatch, then the report
    task automatic give_up(input string what);
        bad_count++;
        $display("CHECK FAILED %0t %s wait ran out", $time, what);
        finish_test();
    endtask

    task automatic on_phase(input int units);
        int k;
        k = 0;
        wait_on();
        while (rx_on === 1'b1 && k < 9000) begin
            @(negedge clock);
            k++;
        end
        if (k == 9000)
            give_up("on phase");
        check(16'(k), 16'(512 * units), "on time");
    endtask

    // Strobe pulses one at a time until the receiver wakes again
    task automatic off_phase(input int mult);
        int k;
        k = 0;
        for (int j = 0; j < 900 && rx_on !== 1'b1; j++) begin
            @(posedge clock);
            strobe_osc <= (j % 12) < 6;
            if (j % 12 == 0)
                k++;
            @(negedge clock);
        end
        if (rx_on !== 1'b1)
            give_up("off phase");
        check(16'(k), 16'(mult), "off strobes");
    endtask

    initial begin
        repeat (4) @(posedge clock);
        check({miso_oe, rx_on, bank_a_active, tag_length}, 16'h0000,
              "rst");
        resetn <= 1'b1;
        repeat (3) @(negedge clock);
        check({bank_a_active, tag_length, preamble_length}, 16'h0034,
              "dec");
        burst(8'h69);
        for (int k = 0; k < 4; k++)
            check(rb[k], rst_vals[k], "reset value");
        // Table of length codes, every code once
        foreach (rows[i]) begin
            wb[0] = rows[i].tcfg;
            wb[1] = rows[i].pcfg;
            burst(8'haa);
            burst(8'h2a);
            check({rb[0], rb[1]}, {rows[i].tcfg, rows[i].pcfg},
                  "rw");
            check({tag_length, tag_value}, {rows[i].tl, rows[i].tv},
                  "tag");
            check({preamble_length, preamble_value},
                  {rows[i].pl, rows[i].pv}, "pre");
        end
        wb[0] = 8'h8f;
        burst(8'h89);
        check(bank_a_active, 1'b1, "bank");
        // The LNA level changes after capture and must not leak in
        @(posedge clock);
        lna_level <= 4'ha;
        if_level <= 4'h5;
        signal_strength_result_valid <= 1'b1;
        @(posedge clock);
        signal_strength_result_valid <= 1'b0;
        lna_level <= 4'h3;
        wb[0] = 8'hff;
        burst(8'h8c);
        burst(8'h2c);
        check(rb[0][7:4], 4'ha, "lna nibble");
        check(rb[0][3:0], 4'h5, "if nibble");
        check(rb[1], 8'h00, "unmapped");
        // Every off code, on code alternating one and two
        for (int c = 0; c < 8; c++) begin
            wb[0] = {1'b0, 4'(c % 2 + 1), 3'(c)};
            burst(8'h89);
            @(posedge clock);
            strobe_en <= 1'b1;
            repeat (20) @(negedge clock);
            check({xtal_enable, rx_on}, 2'b10, "wake");
            @(posedge clock);
            xtal_ready <= 1'b1;
            on_phase(c % 2 + 1);
            off_phase(offm[c]);
            on_phase(c % 2 + 1);
            @(posedge clock);
            strobe_en <= 1'b0;
            xtal_ready <= 1'b0;
            strobe_osc <= 1'b0;
            repeat (8) @(negedge clock);
        end
        finish_test();
    end
endmodule
